// *** rtl/boot_addr_consts.svh ***
// constants for the boot address selector: offsets, field positions,
// reset values and fixed addresses
// assumes a 32-bit classic wishbone register port and 32-bit addresses
//
// Contract
// R01 - boot address comes from pin, inverted option and stored address fields
// R02 - effective boot value comes from pin or option, chosen by select bit
// R03 - no extension, select 1: pin 0 picks field0, pin 1 picks field1
// R04 - no extension, select 0: pin ignored, inverted bit 1 field0, 0 field1
// R05 - factory defaults: flash base, system bootloader, secure flash base
// R06 - with extension the boot location is secure, secure field0 supplies it
// R07 - extension, unlocked: nonzero service command or boot value 1 boots services
// R08 - boot lock set: always secure field0, everything else ignored; code honours it only with extension, and the range check still applies
// R09 - read protection level 0 accepts any programmed address
// R10 - level 0.5 or higher: out-of-range address replaced by forced default
// R11 - extension, level 0.5/1/2: only services entry or secure flash range
// R12 - no extension: level 1 accepts anything, level 2 only flash range
// R13 - booting into security services needs the extension enable bit
// R14 - address computed once at reset release, held until next reset
`ifndef BOOT_ADDR_CONSTS_SVH
`define BOOT_ADDR_CONSTS_SVH

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define BA_OFS_ADDR       8'h00
`define BA_OFS_STATUS     8'h04
`define BA_OFS_PADCTRL    8'h08
`define BA_OFS_PADIN      8'h0c

// ----------------------------------------------------------------------
// status and pad control field positions
// ----------------------------------------------------------------------
`define BA_ST_VALID       0
`define BA_ST_FORCED      1
`define BA_ST_SECEXT      2
`define BA_ST_SRC_LO      3
`define BA_ST_SRC_HI      4
`define BA_ST_FREED       5
`define BA_PAD_OUT        0
`define BA_PAD_DRIVE      1

// ----------------------------------------------------------------------
// address fields hold bits [31:7] of the boot address
// ----------------------------------------------------------------------
`define BA_FIELD_SHIFT    7
`define BA_FACT_NS0       25'h0100000
`define BA_FACT_NS1       25'h017f200
`define BA_FACT_SEC0      25'h0180000

// ----------------------------------------------------------------------
// fixed addresses, permitted ranges and reset values
// ----------------------------------------------------------------------
`define BA_RSS_ENTRY      32'h0ff80000
`define BA_SEC_LO         32'h0c000000
`define BA_SEC_HI         32'h0c1fffff
`define BA_FLASH_LO       32'h08000000
`define BA_FLASH_HI       32'h081fffff
`define BA_RESET_ADDR     32'h00000000
`define BA_PADCTRL_RESET  2'h0

`endif

// *** rtl/boot_addr_pkg.sv ***
// types shared by the boot address selector and its bench
// assumes the constants header is included by whoever needs numbers
package boot_addr_pkg;

    // read protection level as stored in the option area
    typedef enum logic [1:0] {
        RDP_L0  = 2'h0,
        RDP_L05 = 2'h1,
        RDP_L1  = 2'h2,
        RDP_L2  = 2'h3
    } rdp_level_t;

    // which source supplied the resolved address
    typedef enum logic [1:0] {
        SRC_NS0  = 2'h0,
        SRC_NS1  = 2'h1,
        SRC_SEC0 = 2'h2,
        SRC_RSS  = 2'h3
    } boot_src_t;

    // resolution sequencer, one-hot
    typedef enum logic [1:0] {
        ST_RESOLVE = 2'h1,
        ST_HOLD    = 2'h2
    } resolve_state_t;

endpackage : boot_addr_pkg

// *** rtl/boot_address_selector.sv ***
// boot address selector: resolves the boot entry address once after
// system reset from the boot pin and the stored option bits, applies the
// read protection range check, and lets software use the pad as a plain
// output once the option bits have released it
// assumes option inputs are stable around reset release and that a
// classic wishbone master reaches the registers
`timescale 1ns/1ns
`include "boot_addr_consts.svh"

module boot_address_selector #(
    parameter int RSS_CMD_W = 8
) (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // classic wishbone slave
    input  wire logic                  wbCyc,
    input  wire logic                  wbStb,
    input  wire logic                  wbWe,
    input  wire logic [7:0]            wbAdr,
    input  wire logic [3:0]            wbSel,
    input  wire logic [31:0]           wbDatI,
    output logic      [31:0]           wbDatO,
    output logic                       wbAck,
    // boot pin pad, two-way
    input  wire logic                  bootPinIn,
    output logic                       bootPinOut,
    output logic                       bootPinOeN,
    // stored option bits
    input  wire logic                  optionsErased,
    input  wire logic                  invertedBootSelectOption,
    input  wire logic                  bootSourceSelectN,
    input  wire logic                  securityExtensionEnable,
    input  wire logic                  bootLock,
    input  wire logic [24:0]           nonsecureBootAddrField0,
    input  wire logic [24:0]           nonsecureBootAddrField1,
    input  wire logic [24:0]           secureBootAddrField0,
    input  wire boot_addr_pkg::rdp_level_t readProtectionLevel,
    input  wire logic [RSS_CMD_W-1:0]  rootSecurityCommand,
    // resolved boot result
    output logic [31:0]                bootAddr,
    output logic                       bootValid,
    output boot_addr_pkg::boot_src_t   bootSource,
    output logic                       bootForced
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        boot_addr_pkg::resolve_state_t st;
        logic [31:0]                   addr;
        logic                          valid;
        boot_addr_pkg::boot_src_t      src;
        logic                          forced;
        logic                          secExt;
        logic                          padFreed;
        logic [1:0]                    padCtrl;
        logic                          padOeN;
        logic                          ack;
        logic [31:0]                   datO;
    } sel_state_t;

    sel_state_t s_reg;
    sel_state_t s_next;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // widen a 25-bit field to a byte address
    function automatic logic [31:0] fieldAddr(input logic [24:0] f);
        fieldAddr = {f, 7'h00};
    endfunction : fieldAddr

    // inclusive range check used for both permitted areas
    function automatic logic inRange(input logic [31:0] a,
                                     input logic [31:0] lo,
                                     input logic [31:0] hi);
        inRange = (a >= lo) && (a <= hi);
    endfunction : inRange

    // ------------------------------------------------------------------
    // option values in force; a blank option area reads as factory data
    // ------------------------------------------------------------------
    logic [24:0] ns0Field;
    logic [24:0] ns1Field;
    logic [24:0] sec0Field;
    logic        effBoot;

    // factory contents stand in while the option area is erased
    always_comb begin
        ns0Field  = optionsErased ? `BA_FACT_NS0  : nonsecureBootAddrField0; // [R05]
        ns1Field  = optionsErased ? `BA_FACT_NS1  : nonsecureBootAddrField1; // [R05]
        sec0Field = optionsErased ? `BA_FACT_SEC0 : secureBootAddrField0;    // [R05]
        // select 1 follows the pad, select 0 follows the inverted option
        effBoot   = bootSourceSelectN ? bootPinIn                  // [R02]
                                      : ~invertedBootSelectOption; // [R02]
    end

    // ------------------------------------------------------------------
    // address resolution, purely from the current pin and option inputs
    // ------------------------------------------------------------------
    logic [31:0]              rawAddr;
    boot_addr_pkg::boot_src_t rawSrc;
    logic [31:0]              finAddr;
    boot_addr_pkg::boot_src_t finSrc;
    logic                     finForced;
    logic                     permitted;

    // pick the programmed entry, then clamp it by protection level
    always_comb begin
        rawAddr   = fieldAddr(ns0Field);
        rawSrc    = boot_addr_pkg::SRC_NS0;
        permitted = 1'b1;
        if (!securityExtensionEnable) begin
            // services entry is never reachable here
            if (effBoot) begin                                        // [R13]
                rawAddr = fieldAddr(ns1Field);                       // [R03] [R04]
                rawSrc  = boot_addr_pkg::SRC_NS1;
            end else begin
                rawAddr = fieldAddr(ns0Field);                       // [R03] [R04]
                rawSrc  = boot_addr_pkg::SRC_NS0;
            end
            // level 1 and 0.5 accept anything, level 2 only flash
            if (readProtectionLevel == boot_addr_pkg::RDP_L2) begin  // [R12]
                permitted = inRange(rawAddr, `BA_FLASH_LO, `BA_FLASH_HI);
            end
        end else begin
            if (bootLock) begin
                // lock hides pin, option bits and the service command
                rawAddr = fieldAddr(sec0Field);                      // [R08]
                rawSrc  = boot_addr_pkg::SRC_SEC0;
            end else if ((rootSecurityCommand != '0) || effBoot) begin
                rawAddr = `BA_RSS_ENTRY;                             // [R07] [R13]
                rawSrc  = boot_addr_pkg::SRC_RSS;
            end else begin
                rawAddr = fieldAddr(sec0Field);                      // [R06] [R07]
                rawSrc  = boot_addr_pkg::SRC_SEC0;
            end
            // any level above 0 restricts to services entry or secure flash
            if (readProtectionLevel != boot_addr_pkg::RDP_L0) begin  // [R11]
                permitted = (rawAddr == `BA_RSS_ENTRY) ||
                            inRange(rawAddr, `BA_SEC_LO, `BA_SEC_HI);
            end
        end
        // level 0 never forces; permitted stays set for it   [R09]
        finForced = ~permitted;                                      // [R10]
        finAddr   = rawAddr;
        finSrc    = rawSrc;
        if (!permitted) begin
            if (securityExtensionEnable) begin
                finAddr = `BA_RSS_ENTRY;                             // [R10] [R11]
                finSrc  = boot_addr_pkg::SRC_RSS;
            end else begin
                finAddr = `BA_FLASH_LO;                              // [R10] [R12]
                finSrc  = boot_addr_pkg::SRC_NS0;
            end
        end
    end

    // ------------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------------
    logic        busReq;
    logic        busWrite;
    logic [31:0] rdData;

    // read mux; unmapped offsets answer with zero
    always_comb begin
        busReq   = wbCyc && wbStb && !s_reg.ack;
        busWrite = wbCyc && wbStb && wbWe && s_reg.ack;
        rdData   = 32'h00000000;
        case (wbAdr)
            `BA_OFS_ADDR: begin
                rdData = s_reg.addr;
            end
            `BA_OFS_STATUS: begin
                rdData[`BA_ST_VALID]                 = s_reg.valid;
                rdData[`BA_ST_FORCED]                = s_reg.forced;
                rdData[`BA_ST_SECEXT]                = s_reg.secExt;
                rdData[`BA_ST_SRC_HI:`BA_ST_SRC_LO]  = s_reg.src;
                rdData[`BA_ST_FREED]                 = s_reg.padFreed;
            end
            `BA_OFS_PADCTRL: begin
                rdData[1:0] = s_reg.padCtrl;
            end
            `BA_OFS_PADIN: begin
                rdData[0] = bootPinIn;
            end
            default: begin
                rdData = 32'h00000000;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    // resolution runs in the first cycle after reset and then freezes, so
    // later option or pin changes cannot move the entry point
    always_comb begin
        s_next = s_reg;
        case (s_reg.st)
            boot_addr_pkg::ST_RESOLVE: begin
                s_next.addr     = finAddr;                           // [R01] [R14]
                s_next.src      = finSrc;
                s_next.forced   = finForced;
                s_next.secExt   = securityExtensionEnable;
                s_next.padFreed = ~bootSourceSelectN;                // [R02]
                s_next.valid    = 1'b1;
                s_next.st       = boot_addr_pkg::ST_HOLD;
            end
            boot_addr_pkg::ST_HOLD: begin
                s_next.st = boot_addr_pkg::ST_HOLD;                  // [R14]
            end
            default: begin
                s_next.st = boot_addr_pkg::ST_RESOLVE;
            end
        endcase
        // one-cycle ack; the write lands on the edge the master sees it
        s_next.ack = busReq;
        if (busReq) begin
            s_next.datO = rdData;
        end
        if (busWrite && (wbAdr == `BA_OFS_PADCTRL) && wbSel[0]) begin
            s_next.padCtrl = wbDatI[1:0];
        end
        // enable kept in its own flop so the pad never sees a gate glitch
        s_next.padOeN = ~(s_next.padFreed &&
                          s_next.padCtrl[`BA_PAD_DRIVE]);            // [R02]
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            s_reg.st       <= boot_addr_pkg::ST_RESOLVE;
            s_reg.addr     <= `BA_RESET_ADDR;
            s_reg.valid    <= 1'b0;
            s_reg.src      <= boot_addr_pkg::SRC_NS0;
            s_reg.forced   <= 1'b0;
            s_reg.secExt   <= 1'b0;
            s_reg.padFreed <= 1'b0;
            s_reg.padCtrl  <= `BA_PADCTRL_RESET;
            s_reg.padOeN   <= 1'b1;
            s_reg.ack      <= 1'b0;
            s_reg.datO     <= 32'h00000000;
        end else begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------------
    // outputs, all straight from the state register
    // ------------------------------------------------------------------
    // the pad is only driven once boot no longer depends on it
    always_comb begin
        wbAck      = s_reg.ack;
        wbDatO     = s_reg.datO;
        bootAddr   = s_reg.addr;
        bootValid  = s_reg.valid;
        bootSource = s_reg.src;
        bootForced = s_reg.forced;
        bootPinOut = s_reg.padCtrl[`BA_PAD_OUT];
        bootPinOeN = s_reg.padOeN;                                   // [R02]
    end

endmodule : boot_address_selector

// *** sim/boot_address_selector_properties.sv ***
// checker for the boot address selector, bound to its top module
// assumes the constants header is on the include path
`timescale 1ns/1ns
`include "boot_addr_consts.svh"
module boot_address_selector_properties #(
    parameter int RSS_CMD_W = 8
) (
    // clock, reset and bus handshake
    input wire logic                      clk,
    input wire logic                      rst,
    input wire logic                      wbCyc,
    input wire logic                      wbStb,
    input wire logic                      wbAck,
    // pad
    input wire logic                      bootPinIn,
    input wire logic                      bootPinOeN,
    // option bits
    input wire logic                      invertedBootSelectOption,
    input wire logic                      bootSourceSelectN,
    input wire logic                      securityExtensionEnable,
    input wire logic                      bootLock,
    input wire boot_addr_pkg::rdp_level_t readProtectionLevel,
    input wire logic [RSS_CMD_W-1:0]      rootSecurityCommand,
    // result
    input wire logic [31:0]               bootAddr,
    input wire logic                      bootValid,
    input wire boot_addr_pkg::boot_src_t  bootSource,
    input wire logic                      bootForced
);
    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // first edge with reset low is where inputs are sampled
    sequence relEdge;
        $past(rst) && !rst;
    endsequence

    a_valid_release: assert property (relEdge |=> bootValid)
        else $error("result not valid after reset release");
    a_hold_result: assert property (bootValid |=> bootValid && $stable(bootAddr))
        else $error("resolved address moved before reset");
    a_pin_source: assert property (relEdge ##0 (!securityExtensionEnable
        && bootSourceSelectN && readProtectionLevel == boot_addr_pkg::RDP_L0)
        |=> bootSource == (bootPinIn ? boot_addr_pkg::SRC_NS1
                                     : boot_addr_pkg::SRC_NS0))
        else $error("pin did not pick the field");
    a_option_source: assert property (relEdge ##0 (!securityExtensionEnable
        && !bootSourceSelectN && readProtectionLevel == boot_addr_pkg::RDP_L0)
        |=> bootSource == (invertedBootSelectOption ? boot_addr_pkg::SRC_NS0
                                                    : boot_addr_pkg::SRC_NS1))
        else $error("option bit did not pick the field");
    a_lock_secure: assert property (relEdge ##0 (securityExtensionEnable
        && bootLock && readProtectionLevel == boot_addr_pkg::RDP_L0)
        |=> bootSource == boot_addr_pkg::SRC_SEC0)
        else $error("locked boot left secure field");
    a_command_services: assert property (relEdge ##0 (securityExtensionEnable
        && !bootLock && |rootSecurityCommand) |=> bootAddr == `BA_RSS_ENTRY)
        else $error("service command ignored");
    a_services_need_ext: assert property (relEdge ##0 !securityExtensionEnable
        |=> bootSource != boot_addr_pkg::SRC_RSS)
        else $error("services entered without extension");
    a_level0_free: assert property (relEdge ##0
        readProtectionLevel == boot_addr_pkg::RDP_L0 |=> !bootForced)
        else $error("address forced at level 0");
    a_forced_default: assert property (bootValid && bootForced
        |-> bootAddr == `BA_RSS_ENTRY || bootAddr == `BA_FLASH_LO)
        else $error("forced address is not a default");
    a_pad_freed: assert property (!bootPinOeN |-> bootValid)
        else $error("pad driven before resolution");
    a_ack_latency: assert property (wbCyc && wbStb && !wbAck |=> wbAck)
        else $error("bus answer late");

    c_forced: cover property (relEdge ##1 bootForced);
    c_services: cover property (bootValid && bootSource == boot_addr_pkg::SRC_RSS);
    c_pad_driven: cover property (!bootPinOeN);
endmodule : boot_address_selector_properties

bind boot_address_selector boot_address_selector_properties #(
    .RSS_CMD_W(RSS_CMD_W)
) props (.clk, .rst, .wbCyc, .wbStb, .wbAck, .bootPinIn, .bootPinOeN,
    .invertedBootSelectOption, .bootSourceSelectN, .securityExtensionEnable,
    .bootLock, .readProtectionLevel, .rootSecurityCommand, .bootAddr,
    .bootValid, .bootSource, .bootForced);

// *** sim/boot_address_selector_tb.sv ***
// bench for the boot address selector: option cases and bus accesses
// assumes the constants header is on the include path
`timescale 1ns/1ns
`include "boot_addr_consts.svh"
module boot_address_selector_tb;
    logic        clk = 1'b0, rst = 1'b1, wbAck, bootPinIn, bootPinOut;
    logic        wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, bootPinOeN;
    logic [7:0]  wbAdr = 8'h00, cmd = 8'h00;
    logic [3:0]  wbSel = 4'h0;
    logic [31:0] wbDatI = 32'h0, wbDatO, bootAddr, rdData;
    logic        strap = 1'b0, erased = 1'b0, inv = 1'b0, selN = 1'b0;
    logic        ext = 1'b0, lock = 1'b0, bootValid, bootForced;
    logic [24:0] ns0 = 25'h0100200, ns1 = 25'h0400000, sec0 = 25'h0180200;
    boot_addr_pkg::rdp_level_t read_protection_level = boot_addr_pkg::RDP_L0;
    boot_addr_pkg::boot_src_t  bootSource;
    int          fails = 0, cmpCount = 0, cycles = 0;

    always #10 clk = ~clk;

    boot_pin_pad_model pad (.strapLevel(strap), .bootPinOut, .bootPinOeN,
        .bootPinIn);
    boot_address_selector #(.RSS_CMD_W(8)) dut (.clk, .rst, .wbCyc, .wbStb,
        .wbWe, .wbAdr, .wbSel, .wbDatI, .wbDatO, .wbAck, .bootPinIn,
        .bootPinOut, .bootPinOeN, .optionsErased(erased),
        .invertedBootSelectOption(inv), .bootSourceSelectN(selN),
        .securityExtensionEnable(ext), .bootLock(lock),
        .nonsecureBootAddrField0(ns0), .nonsecureBootAddrField1(ns1),
        .secureBootAddrField0(sec0), .readProtectionLevel(read_protection_level),
        .rootSecurityCommand(cmd), .bootAddr, .bootValid, .bootSource,
        .bootForced);

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmpCount, fails);
        if (fails == 0 && cmpCount > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : results

    // a hang counts as a mismatch and still reaches the verdict
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            results();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, exp);
        cmpCount++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // classic single cycle; request held until ack is sampled
    task automatic wbXfer(input logic we, input logic [7:0] adr,
                          input logic [31:0] dat);
        @(posedge clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbSel <= 4'hf;
        wbDatI <= dat;
        do @(posedge clk); while (wbAck !== 1'b1);
        rdData = wbDatO;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
    endtask : wbXfer

    // options settle under reset, then the result is checked and held
    task automatic run(input logic e, l, s, i, p, input logic [1:0] r,
        input logic [7:0] c, input logic [31:0] ea, input logic [1:0] es,
        input logic ef);
        @(posedge clk);
        rst <= 1'b1;
        ext <= e;
        lock <= l;
        selN <= s;
        inv <= i;
        strap <= p;
        read_protection_level <= boot_addr_pkg::rdp_level_t'(r);
        cmd <= c;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        check("bootAddr", bootAddr, ea);
        check("bootForced", bootForced, ef);
        if (!ef) check("bootSource", bootSource, es);
        strap <= ~p;
        ext <= ~e;
        wbXfer(1'b0, `BA_OFS_ADDR, 32'h0);
        check("addrReg", rdData, ea);
        check("held", bootAddr, ea);
        $display("case done addr %h", ea);
    endtask : run

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        run(0, 0, 1, 0, 0, 0, 0, 32'h08010000, 0, 0);
        run(0, 0, 1, 1, 1, 0, 0, 32'h20000000, 1, 0);
        run(0, 0, 0, 0, 0, 0, 0, 32'h20000000, 1, 0);
        run(0, 0, 0, 1, 1, 0, 0, 32'h08010000, 0, 0);
        wbXfer(1'b1, `BA_OFS_PADCTRL, 32'h3);
        @(posedge clk);
        check("padOeN", bootPinOeN, 1'b0);
        wbXfer(1'b0, `BA_OFS_PADIN, 32'h0);
        check("padIn", rdData, 32'h1);
        wbXfer(1'b1, `BA_OFS_ADDR, 32'h5a5a5a00);
        wbXfer(1'b0, `BA_OFS_ADDR, 32'h0);
        check("roAddr", rdData, 32'h08010000);
        wbXfer(1'b0, 8'h10, 32'h0);
        check("unmapped", rdData, 32'h0);
        run(1, 1, 0, 0, 1, 0, 5, 32'h0c010000, 2, 0);
        wbXfer(1'b0, `BA_OFS_STATUS, 32'h0);
        check("status", rdData, 32'h00000035);
        run(1, 0, 1, 0, 0, 0, 5, 32'h0ff80000, 3, 0);
        run(1, 0, 1, 0, 0, 0, 0, 32'h0c010000, 2, 0);
        run(1, 0, 1, 0, 1, 0, 0, 32'h0ff80000, 3, 0);
        run(1, 0, 0, 0, 0, 0, 0, 32'h0ff80000, 3, 0);
        run(1, 0, 0, 1, 1, 0, 0, 32'h0c010000, 2, 0);
        run(0, 0, 1, 0, 1, 3, 0, 32'h08000000, 0, 1);
        wbXfer(1'b1, `BA_OFS_PADCTRL, 32'h3);
        @(posedge clk);
        check("padHeld", bootPinOeN, 1'b1);
        run(0, 0, 1, 0, 1, 2, 0, 32'h20000000, 1, 0);
        run(0, 0, 1, 0, 0, 3, 0, 32'h08010000, 0, 0);
        run(0, 0, 1, 0, 1, 1, 0, 32'h20000000, 1, 0);
        sec0 <= 25'h0400000;
        run(1, 1, 0, 0, 0, 2, 0, 32'h0ff80000, 0, 1);
        run(1, 1, 0, 0, 0, 1, 0, 32'h0ff80000, 0, 1);
        run(1, 1, 0, 0, 0, 0, 0, 32'h20000000, 2, 0);
        sec0 <= 25'h0183fff;
        run(1, 1, 0, 0, 0, 3, 0, 32'h0c1fff80, 2, 0);
        erased <= 1'b1;
        run(0, 0, 1, 0, 0, 0, 0, 32'h08000000, 0, 0);
        run(0, 0, 1, 0, 1, 0, 0, 32'h0bf90000, 1, 0);
        run(1, 1, 0, 0, 0, 0, 0, 32'h0c000000, 2, 0);
        results();
    end
endmodule : boot_address_selector_tb

// *** sim/boot_pin_pad_model.sv ***
// pad model for the boot pin: resolves the level of the two-way pad
// assumes the bench sets the level an outside strap applies
`timescale 1ns/1ns
module boot_pin_pad_model (
    // outside strap and block driver
    input  wire logic strapLevel,
    input  wire logic bootPinOut,
    input  wire logic bootPinOeN,
    // level seen by the block
    output logic      bootPinIn
);
    // the block overrides the weak strap once it drives the freed pad
    assign bootPinIn = bootPinOeN ? strapLevel : bootPinOut;
endmodule : boot_pin_pad_model
